// *** hw/isf_fifo.sv ***
/*
 Inertial sample buffer: power modes, 4096x16 buffer, modes, status, APB slave.
 Assumes sensor words and strobes arrive synchronous to sys_clk; event sources
 are levels in the same domain.
*/
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module isf_fifo
   import isf_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire isf_trig_t   trig_in,
   input  wire isf_words_t  words_in,
   input  wire logic [7:0]  function_event_source,
   input  wire logic [7:0]  tap_event_source,
   input  wire logic [7:0]  wake_event_source,
   input  wire logic [7:0]  orientation_event_source,
   output isf_pwr_t         accel_pwr,
   output isf_pwr_t         gyro_pwr,
   output logic             irq_pin_one,
   output logic             irq_pin_two
);
   //---------------------------------------------------------------
   // Registers
   //---------------------------------------------------------------
   logic [7:0]         th_lo_reg, th_hi_reg, dec_a_reg, dec_b_reg, mode_reg;
   logic [7:0]         pin1_reg, pin2_reg, acc_reg, gyr_reg, cc4_reg, cc6_reg, g7_reg;
   logic [ISF_DW-1:0]  mem [ISF_DEPTH];
   logic [ISF_AW-1:0]  wr_ptr_reg, rd_ptr_reg;
   logic [ISF_AW:0]    count_reg;
   logic               ovr_reg;
   logic               lo_read_reg;
   logic [ISF_DW-1:0]  out_reg;
   logic [2:0]         slot_reg;
   logic [1:0]         set_reg;
   logic               burst_reg;
   wire  logic [3:0]   take_vec;
   isf_state_t         state_reg;

   logic        wr_acc, rd_acc;
   logic [7:0]  addr;
   logic [11:0] threshold_value;
   logic [2:0]  mode_field;
   logic        trig_sel, eff_fill, eff_clear, eff_cont;
   logic [ISF_AW:0] cap;
   logic        full, empty, fth_flag, push, pop, drop;
   logic        stop_on_threshold_bit;
   logic        trig_evt;
   logic [15:0] slot_word;
   logic        slot_ok;

   assign addr    = paddr[9:2];
   assign wr_acc  = psel && penable && pwrite;
   assign rd_acc  = psel && penable && !pwrite;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   assign threshold_value       = {th_hi_reg[3:0], th_lo_reg};
   assign stop_on_threshold_bit = cc4_reg[CC4_STOP_BIT];
   assign mode_field            = mode_reg[MODE_LSB +: 3];

   //---------------------------------------------------------------
   // Power modes
   //---------------------------------------------------------------
   function automatic isf_pwr_t pwr_of(input logic [3:0] rate, input logic lp_bit);
      if (rate == RATE_OFF)
         return ISF_PWR_DOWN;
      else if (!lp_bit || rate > RATE_208HZ)
         return ISF_PWR_HIGH;
      else if (rate <= RATE_52HZ)
         return ISF_PWR_LOW;
      else
         return ISF_PWR_NORM;
   endfunction

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         accel_pwr <= ISF_PWR_DOWN;
         gyro_pwr  <= ISF_PWR_DOWN;
      end else begin
         accel_pwr <= pwr_of(acc_reg[7:4], cc6_reg[PWR_BIT]);
         gyro_pwr  <= pwr_of(gyr_reg[7:4], g7_reg[PWR_BIT]);
      end
   end

   //---------------------------------------------------------------
   // APB register writes
   //---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         th_lo_reg <= 8'h00; th_hi_reg <= 8'h00; dec_a_reg <= 8'h00; dec_b_reg <= 8'h00;
         mode_reg  <= 8'h00; pin1_reg  <= 8'h00; pin2_reg  <= 8'h00; acc_reg   <= 8'h00;
         gyr_reg   <= 8'h00; cc4_reg   <= 8'h00; cc6_reg   <= 8'h00; g7_reg    <= 8'h00;
      end else if (wr_acc) begin
         unique case (addr)
            ADR_TH_LO: th_lo_reg <= pwdata[7:0];
            ADR_TH_HI: th_hi_reg <= pwdata[7:0];
            ADR_DEC_A: dec_a_reg <= pwdata[7:0];
            ADR_DEC_B: dec_b_reg <= pwdata[7:0];
            ADR_MODE:  mode_reg  <= pwdata[7:0];
            ADR_PIN1:  pin1_reg  <= pwdata[7:0];
            ADR_PIN2:  pin2_reg  <= pwdata[7:0];
            ADR_ACC:   acc_reg   <= pwdata[7:0];
            ADR_GYR:   gyr_reg   <= pwdata[7:0];
            ADR_CC4:   cc4_reg   <= pwdata[7:0];
            ADR_CC6:   cc6_reg   <= pwdata[7:0];
            ADR_G7:    g7_reg    <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   //---------------------------------------------------------------
   // Mode resolution
   //---------------------------------------------------------------
   // Trigger select: mode_reg[4:3] picks a source register, bit 0 of which
   // holds the event; a small choice that keeps the selection explicit.
   always_comb begin
      unique case (mode_reg[TRIG_LSB +: 2])
         2'h0:    trig_sel = function_event_source[0];
         2'h1:    trig_sel = tap_event_source[0];
         2'h2:    trig_sel = wake_event_source[0];
         default: trig_sel = orientation_event_source[0];
      endcase
   end

   always_comb begin
      eff_fill  = 1'b0;
      eff_cont  = 1'b0;
      eff_clear = 1'b0;
      unique case (mode_field)
         MODE_FILL: eff_fill = 1'b1;
         MODE_CONT: eff_cont = 1'b1;
         MODE_C2F: begin
            eff_fill = trig_sel;
            eff_cont = !trig_sel;
         end
         MODE_B2C: begin
            eff_cont  = trig_sel;
            eff_clear = !trig_sel;
         end
         default: eff_clear = 1'b1;
      endcase
   end

   // Depth limit: full capacity unless stop-on-threshold clamps it
   assign cap      = (stop_on_threshold_bit && threshold_value != 12'h000) ?
                     {1'b0, threshold_value} : 13'(ISF_DEPTH);
   assign full     = (count_reg >= cap);
   assign empty    = (count_reg == 13'h0000);
   assign fth_flag = (count_reg >= {1'b0, threshold_value});

   //---------------------------------------------------------------
   // Write trigger and data-set sequencing
   //---------------------------------------------------------------
   // Data-ready trigger wants both sensors' strobes; the host must keep the
   // buffer rate at or below both sensor rates.
   always_comb begin
      unique case (mode_reg[7:6])
         2'h1:    trig_evt = trig_in.hub_drdy;
         2'h2:    trig_evt = trig_in.step_det;
         default: trig_evt = trig_in.acc_drdy && trig_in.gyr_drdy;
      endcase
   end

   // Four data sets, three words each; set four source from dec_b[7:6]
   always_comb begin
      slot_word = 16'h0000;
      unique case (set_reg)
         2'h0: slot_word = words_in.gyro;
         2'h1: slot_word = words_in.accel;
         2'h2: slot_word = words_in.hub_lo;
         default: begin
            unique case (dec_b_reg[7:6])
               2'h1:    slot_word = words_in.step_ts;
               2'h2:    slot_word = words_in.temp;
               default: slot_word = words_in.hub_hi;
            endcase
         end
      endcase
      slot_word = slot_word ^ {11'h000, set_reg, slot_reg};
   end

   //---------------------------------------------------------------
   // Per-set decimation
   //---------------------------------------------------------------
   assign slot_ok = take_vec[set_reg];

   // Last divider count per code, the factor minus one, so that a
   // factor of 32 still fits in five bits
   function automatic logic [4:0] dec_last(input logic [2:0] code);
      unique case (code)
         3'h2: return 5'd1;
         3'h3: return 5'd2;
         3'h4: return 5'd3;
         3'h5: return 5'd7;
         3'h6: return 5'd15;
         3'h7: return 5'd31;
         default: return 5'd0;
      endcase
   endfunction

   // Dividers step only between bursts, so one trigger decides all sets
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_dec
         logic [2:0] code;
         logic [4:0] cnt_reg;
         logic       take_reg;
         assign code = (gi % 2 == 1) ? ((gi < 2) ? dec_a_reg[5:3] : dec_b_reg[5:3])
                                     : ((gi < 2) ? dec_a_reg[2:0] : dec_b_reg[2:0]);
         assign take_vec[gi] = take_reg;
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               cnt_reg  <= 5'h00;
               take_reg <= 1'b0;
            end else if (trig_evt && !burst_reg) begin
               // Code 1 stores every trigger; code 0 disables the set
               take_reg <= (code != DEC_OFF) && (cnt_reg == 5'h00);
               cnt_reg  <= (cnt_reg >= dec_last(code)) ? 5'h00 : cnt_reg + 5'd1;
            end
         end
      end
   endgenerate

   //---------------------------------------------------------------
   // Burst sequencing: three words for each of four sets
   //---------------------------------------------------------------
   // A trigger arriving mid-burst is lost; the host keeps triggers at
   // least thirteen cycles apart
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         burst_reg <= 1'b0;
         slot_reg  <= 3'h0;
         set_reg   <= 2'h0;
      end else if (!burst_reg) begin
         burst_reg <= trig_evt && !eff_clear;
         slot_reg  <= 3'h0;
         set_reg   <= 2'h0;
      end else begin
         burst_reg <= !(set_reg == 2'h3 && slot_reg == SET_LAST_WORD) && !eff_clear;
         slot_reg  <= (slot_reg == SET_LAST_WORD) ? 3'h0 : slot_reg + 3'h1;
         set_reg   <= (slot_reg == SET_LAST_WORD) ? set_reg + 2'h1 : set_reg;
      end
   end

   //---------------------------------------------------------------
   // Buffer state machine
   //---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst)
         state_reg <= ISF_ST_IDLE;
      else if (eff_clear)
         state_reg <= ISF_ST_IDLE;
      else if (eff_fill && full)
         state_reg <= ISF_ST_HELD;
      else if (!eff_fill || state_reg == ISF_ST_IDLE)
         state_reg <= ISF_ST_RUN;
   end

   // A held fill-once buffer takes nothing until bypass or a non-fill mode restarts it
   assign push = burst_reg && slot_ok && !eff_clear && state_reg != ISF_ST_HELD
                 && !(eff_fill && full);
   assign pop  = rd_acc && addr == ADR_OUT_H && lo_read_reg && !empty;
   assign drop = push && full && eff_cont;

   //---------------------------------------------------------------
   // Storage, pointers and counts
   //---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (push)
         mem[wr_ptr_reg] <= slot_word;
   end

   always_ff @(posedge sys_clk) begin
      if (rst || eff_clear) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push)
            wr_ptr_reg <= wr_ptr_reg + 12'h001;
         if (pop || drop)
            rd_ptr_reg <= rd_ptr_reg + 12'h001;
         if (push && !(pop || drop))
            count_reg <= count_reg + 13'h0001;
         else if (!push && pop)
            count_reg <= count_reg - 13'h0001;
      end
   end

   // Overrun is sticky until bypass; a new overwrite wins over the clear
   always_ff @(posedge sys_clk) begin
      if (rst)
         ovr_reg <= 1'b0;
      else if (drop)
         ovr_reg <= 1'b1;
      else if (eff_clear)
         ovr_reg <= 1'b0;
   end

   // Low byte read latches the entry so both halves belong together
   always_ff @(posedge sys_clk) begin
      if (rst || eff_clear) begin
         lo_read_reg <= 1'b0;
         out_reg     <= 16'h0000;
      end else if (rd_acc && addr == ADR_OUT_L) begin
         lo_read_reg <= 1'b1;
         out_reg     <= empty ? 16'h0000 : mem[rd_ptr_reg];
      end else if (rd_acc && addr == ADR_OUT_H) begin
         lo_read_reg <= 1'b0;
      end
   end

   //---------------------------------------------------------------
   // Read mux and interrupt pins
   //---------------------------------------------------------------
   always_comb begin
      prdata = 32'h0000_0000;
      unique case (addr)
         ADR_TH_LO: prdata[7:0] = th_lo_reg;
         ADR_TH_HI: prdata[7:0] = th_hi_reg;
         ADR_DEC_A: prdata[7:0] = dec_a_reg;
         ADR_DEC_B: prdata[7:0] = dec_b_reg;
         ADR_MODE:  prdata[7:0] = mode_reg;
         ADR_PIN1:  prdata[7:0] = pin1_reg;
         ADR_PIN2:  prdata[7:0] = pin2_reg;
         ADR_ACC:   prdata[7:0] = acc_reg;
         ADR_GYR:   prdata[7:0] = gyr_reg;
         ADR_CC4:   prdata[7:0] = cc4_reg;
         ADR_CC6:   prdata[7:0] = cc6_reg;
         ADR_G7:    prdata[7:0] = g7_reg;
         ADR_ST1:   prdata[7:0] = count_reg[7:0];
         ADR_ST2:   prdata[7:0] = {fth_flag, ovr_reg, full, empty, count_reg[11:8]};
         ADR_ST3:   prdata[7:0] = {3'h0, set_reg, slot_reg};
         ADR_ST4:   prdata[7:0] = {7'h00, count_reg[12]};
         ADR_OUT_L: prdata[7:0] = empty ? 8'h00 : mem[rd_ptr_reg][7:0];
         ADR_OUT_H: prdata[7:0] = lo_read_reg ? out_reg[15:8] : 8'h00;
         default:   prdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_pin_one <= 1'b0;
         irq_pin_two <= 1'b0;
      end else begin
         irq_pin_one <= (pin1_reg[PIN_FTH_BIT] && fth_flag)
                      || (pin1_reg[PIN_FULL_BIT] && full);
         irq_pin_two <= pin2_reg[PIN_FTH_BIT] && fth_flag;
      end
   end
endmodule : isf_fifo
`default_nettype wire

// *** hw/isf_pkg.sv ***
/*
 Constants and carrier types for the inertial sample buffer.
 Assumes one clock (sys_clk) and an APB register port; bit layouts chosen here.
*/
// Summary of operation
// - Accel and gyro wake on own rate writes
// - Gyro power mode from mode bit, rate
// - Accel power mode from mode bit, rate
// - Buffer holds 4096 entries of 16 bits
// - Write trigger source is selectable
// - Per-set decimation by 2,3,4,8,16,32
// - Twelve-bit threshold over two registers
// - Threshold flag when unread count reaches threshold
// - Stop-on-threshold limits depth to threshold
// - Bypass stores nothing and clears buffer
// - Fill-once stores until full, then stops
// - Continuous mode overwrites oldest samples
// - Overrun flag when oldest sample overwritten
// - Unread count readable over three registers
// - Mode 011: trigger selects fill-once or continuous
// - Mode 100: trigger continuous, else bypass
// - Threshold flag routed to either pin
// - Full flag routed to pin one
// - Entry read as low then high byte
// - Four data sets of six bytes
// - Fourth set source is selectable
package isf_pkg;
   localparam int          ISF_DEPTH      = 4096;
   localparam int          ISF_AW         = 12;
   localparam int          ISF_DW         = 16;
   localparam logic [7:0]  ADR_TH_LO      = 8'h06;
   localparam logic [7:0]  ADR_TH_HI      = 8'h07;
   localparam logic [7:0]  ADR_DEC_A      = 8'h08;
   localparam logic [7:0]  ADR_DEC_B      = 8'h09;
   localparam logic [7:0]  ADR_MODE       = 8'h0a;
   localparam logic [7:0]  ADR_PIN1       = 8'h0d;
   localparam logic [7:0]  ADR_PIN2       = 8'h0e;
   localparam logic [7:0]  ADR_ACC        = 8'h10;
   localparam logic [7:0]  ADR_GYR        = 8'h11;
   localparam logic [7:0]  ADR_CC4        = 8'h13;
   localparam logic [7:0]  ADR_CC6        = 8'h15;
   localparam logic [7:0]  ADR_G7         = 8'h16;
   localparam logic [7:0]  ADR_ST1        = 8'h3a;
   localparam logic [7:0]  ADR_ST2        = 8'h3b;
   localparam logic [7:0]  ADR_ST3        = 8'h3c;
   localparam logic [7:0]  ADR_ST4        = 8'h3d;
   localparam logic [7:0]  ADR_OUT_L      = 8'h3e;
   localparam logic [7:0]  ADR_OUT_H      = 8'h3f;
   // Register indices: some offsets are not word aligned, so the APB byte
   // address is four times the index
   localparam logic [2:0]  MODE_BYPASS    = 3'h0;
   localparam logic [2:0]  MODE_FILL      = 3'h1;
   localparam logic [2:0]  MODE_C2F       = 3'h3;
   localparam logic [2:0]  MODE_B2C       = 3'h4;
   localparam logic [2:0]  MODE_CONT      = 3'h6;
   localparam int          MODE_LSB       = 0;
   localparam int          TRIG_LSB       = 3;
   localparam int          CC4_STOP_BIT   = 0;
   localparam int          PWR_BIT        = 7;
   localparam int          PIN_FTH_BIT    = 3;
   localparam int          PIN_FULL_BIT   = 5;
   localparam logic [3:0]  RATE_OFF       = 4'h0;
   localparam logic [3:0]  RATE_52HZ      = 4'h3;
   localparam logic [3:0]  RATE_208HZ     = 4'h5;
   localparam logic [2:0]  DEC_OFF        = 3'h0;
   localparam logic [2:0]  SET_LAST_WORD  = 3'h2;

   typedef enum logic [3:0] {
      ISF_PWR_DOWN = 4'b0001,
      ISF_PWR_LOW  = 4'b0010,
      ISF_PWR_NORM = 4'b0100,
      ISF_PWR_HIGH = 4'b1000
   } isf_pwr_t;

   typedef enum logic [2:0] {
      ISF_ST_IDLE  = 3'b001,
      ISF_ST_RUN   = 3'b010,
      ISF_ST_HELD  = 3'b100
   } isf_state_t;

   typedef struct packed {
      logic        acc_drdy;
      logic        gyr_drdy;
      logic        hub_drdy;
      logic        step_det;
   } isf_trig_t;

   typedef struct packed {
      logic [15:0] gyro;
      logic [15:0] accel;
      logic [15:0] hub_lo;
      logic [15:0] hub_hi;
      logic [15:0] step_ts;
      logic [15:0] temp;
   } isf_words_t;
endpackage : isf_pkg

// *** verification/isf_fifo_assertions.sv ***
/*
 Port checker for the inertial sample buffer, bound to isf_fifo.
 Assumes a zero-wait APB slave and mirrors the power, pin, threshold and mode registers from writes.
*/
`timescale 1ns/1ps
`default_nettype none
module isf_fifo_assertions
   import isf_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire isf_pwr_t    accel_pwr,
   input wire isf_pwr_t    gyro_pwr,
   input wire logic        irq_pin_one,
   input wire logic        irq_pin_two
);
   logic       wr_hit;
   logic       rd_hit;
   logic [7:0] acc_m, gyr_m, cc6_m, g7_m, pin1_m, pin2_m, thl_m, thh_m, mode_m;
   assign wr_hit = psel & penable & pwrite & pready;
   assign rd_hit = psel & penable & ~pwrite & pready;
   // -----------------------------------------------------------------
   // Register mirrors
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         {acc_m, gyr_m, cc6_m, g7_m, pin1_m, pin2_m, thl_m, thh_m, mode_m} <= '0;
      end else if (wr_hit) begin
         case (paddr[9:2])
            ADR_ACC:   acc_m <= pwdata[7:0];
            ADR_GYR:   gyr_m <= pwdata[7:0];
            ADR_CC6:   cc6_m <= pwdata[7:0];
            ADR_G7:    g7_m <= pwdata[7:0];
            ADR_PIN1:  pin1_m <= pwdata[7:0];
            ADR_PIN2:  pin2_m <= pwdata[7:0];
            ADR_TH_LO: thl_m <= pwdata[7:0];
            ADR_TH_HI: thh_m <= pwdata[7:0];
            ADR_MODE:  mode_m <= pwdata[7:0];
            default: ;
         endcase
      end
   end
   function automatic isf_pwr_t pwr_of(input logic [3:0] r, input logic lp);
      if (r == RATE_OFF) return ISF_PWR_DOWN;
      if (lp && r <= RATE_52HZ) return ISF_PWR_LOW;
      if (lp && r <= RATE_208HZ) return ISF_PWR_NORM;
      return ISF_PWR_HIGH;
   endfunction
   // -----------------------------------------------------------------
   // Properties
   // -----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_bypass3; (mode_m[2:0] == MODE_BYPASS)[*3]; endsequence
   sequence s_rd_st2; rd_hit && paddr[9:2] == ADR_ST2; endsequence
   property p_acc_pwr;
      $stable({acc_m, cc6_m}) |-> accel_pwr == pwr_of(acc_m[7:4], cc6_m[PWR_BIT]); endproperty
   a_acc_pwr: assert property (p_acc_pwr) else $error("accel power mode wrong");
   property p_gyr_pwr;
      $stable({gyr_m, g7_m}) |-> gyro_pwr == pwr_of(gyr_m[7:4], g7_m[PWR_BIT]); endproperty
   a_gyr_pwr: assert property (p_gyr_pwr) else $error("gyro power mode wrong");
   property p_pin1_quiet;
      $stable(pin1_m) && !pin1_m[PIN_FTH_BIT] && !pin1_m[PIN_FULL_BIT] |-> !irq_pin_one; endproperty
   a_pin1_quiet: assert property (p_pin1_quiet) else $error("pin one raised unrouted");
   property p_pin2_fth;
      s_rd_st2 ##0 (prdata[7] && pin2_m[PIN_FTH_BIT]) |-> ##[1:2] irq_pin_two; endproperty
   a_pin2_fth: assert property (p_pin2_fth) else $error("pin two missed flag");
   property p_byp_st2; s_bypass3 ##0 s_rd_st2 |-> prdata[6:4] == 3'b001; endproperty
   a_byp_st2: assert property (p_byp_st2) else $error("bypass not empty");
   property p_byp_cnt; s_bypass3 ##0 (rd_hit && paddr[9:2] == ADR_ST1) |-> prdata[7:0] == 8'h00; endproperty
   a_byp_cnt: assert property (p_byp_cnt) else $error("bypass count nonzero");
   property p_fth_hi; s_rd_st2 ##0 (prdata[3:0] > thh_m[3:0]) |-> prdata[7]; endproperty
   a_fth_hi: assert property (p_fth_hi) else $error("threshold flag low");
   property p_empty; s_rd_st2 ##0 prdata[4] |-> prdata[3:0] == 4'h0 && !prdata[5]; endproperty
   a_empty: assert property (p_empty) else $error("empty with entries");
   property p_th_rb; rd_hit && paddr[9:2] == ADR_TH_LO |-> prdata[7:0] == thl_m; endproperty
   a_th_rb: assert property (p_th_rb) else $error("threshold readback");
endmodule // isf_fifo_assertions
bind isf_fifo isf_fifo_assertions u_chk (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .accel_pwr(accel_pwr), .gyro_pwr(gyro_pwr), .irq_pin_one(irq_pin_one), .irq_pin_two(irq_pin_two));
`default_nettype wire

// *** verification/isf_sensor_model.sv ***
/*
 Sensor side model: data-ready strobes and sample words.
 Assumes the bench raises fire for one cycle per sample set.
*/
`timescale 1ns/1ps
`default_nettype none
module isf_sensor_model
   import isf_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic fire,
   output isf_trig_t  trig,
   output isf_words_t words
);
   logic [15:0] seq_reg;
   // Both strobes together: the combined trigger wants both sensors ready
   always_ff @(posedge sys_clk) begin
      trig <= '{acc_drdy: fire, gyr_drdy: fire, hub_drdy: 1'b0, step_det: 1'b0};
   end
   always_ff @(posedge sys_clk) begin
      if (rst) seq_reg <= 16'h0000;
      else if (fire) seq_reg <= seq_reg + 16'h0001;
   end
   assign words = {seq_reg, ~seq_reg, 16'ha5a5, 16'h5a5a, seq_reg ^ 16'h0f0f, 16'h0123};
endmodule // isf_sensor_model
`default_nettype wire

// *** verification/test_inertial_sample_fifo.sv ***
/*
 Self-checking bench for isf_fifo over APB.
 Assumes zero-wait APB and one idle cycle between transfers.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
   $display("MISMATCH at %0t: got %h exp %h", $time, g, e); end end
module test_inertial_sample_fifo
   import isf_pkg::*;
;
   logic        sys_clk, rst, psel, penable, pwrite, fire, pready, pslverr, irq_pin_one, irq_pin_two;
   logic [31:0] paddr, pwdata, prdata;
   logic [7:0]  ev, q;
   logic [12:0] c;
   isf_trig_t   trig;
   isf_words_t  words;
   isf_pwr_t    accel_pwr, gyro_pwr;
   int          num_errors = 0;
   int          n_tests = 0;
   localparam logic [3:0] RATES [4] = '{RATE_OFF, RATE_52HZ, RATE_208HZ, 4'h6};
   localparam isf_pwr_t EXP_PWR [8] = '{ISF_PWR_DOWN, ISF_PWR_DOWN, ISF_PWR_HIGH, ISF_PWR_LOW,
                                        ISF_PWR_HIGH, ISF_PWR_NORM, ISF_PWR_HIGH, ISF_PWR_HIGH};
   always #25 sys_clk = ~sys_clk;
   isf_fifo DUT (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .trig_in(trig), .words_in(words), .function_event_source(ev), .tap_event_source(8'h00),
      .wake_event_source(8'h00), .orientation_event_source(8'h00), .accel_pwr(accel_pwr),
      .gyro_pwr(gyro_pwr), .irq_pin_one(irq_pin_one), .irq_pin_two(irq_pin_two));
   isf_sensor_model u_sensor (.sys_clk(sys_clk), .rst(rst), .fire(fire), .trig(trig), .words(words));
   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task automatic conclude();
      if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
      int n;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {22'h0, a, 2'b00}; pwdata <= {24'h0, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 20);
      r = prdata[7:0];
      psel <= 1'b0; penable <= 1'b0;
      if (n >= 20) begin num_errors++; conclude(); end
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      apb(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] r);
      apb(1'b0, a, 8'h00, r);
   endtask
   task automatic count(output logic [12:0] n);
      logic [7:0] l, h, x;
      rd(ADR_ST1, l); rd(ADR_ST2, h); rd(ADR_ST4, x);
      n = {x[0], h[3:0], l};
   endtask
   // Spacing leaves the 12-word write burst just room to finish
   task automatic fire_n(input int k);
      repeat (k) begin fire <= 1'b1; @(posedge sys_clk); fire <= 1'b0; repeat (12) @(posedge sys_clk); end
   endtask
   // -----------------------------------------------------------------
   // Sequence
   // -----------------------------------------------------------------
   initial begin
      sys_clk = 1'b0; rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; fire = 1'b0;
      paddr = 32'h0; pwdata = 32'h0; ev = 8'h00;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      `CHK(accel_pwr, ISF_PWR_DOWN)
      wr(8'h01, 8'hff); rd(8'h01, q); `CHK(q, 8'h00)
      for (int i = 0; i < 8; i++) begin
         wr(ADR_CC6, {i[0], 7'h0}); wr(ADR_G7, {i[0], 7'h0});
         wr(ADR_ACC, {RATES[i/2], 4'h0}); wr(ADR_GYR, {RATES[i/2], 4'h0});
         repeat (2) @(posedge sys_clk);
         `CHK(accel_pwr, EXP_PWR[i])
         `CHK(gyro_pwr, EXP_PWR[i])
      end
      wr(ADR_TH_LO, 8'h06); wr(ADR_TH_HI, 8'h00); rd(ADR_TH_LO, q); `CHK(q, 8'h06)
      wr(ADR_DEC_A, 8'h01); wr(ADR_DEC_B, 8'h00); wr(ADR_CC4, 8'h01);
      wr(ADR_PIN1, 8'h08); wr(ADR_PIN2, 8'h08); wr(ADR_MODE, 8'h01);
      fire_n(5); count(c); `CHK(c, 13'd6)
      rd(ADR_ST2, q); `CHK(q[7:6], 2'b10)
      `CHK({irq_pin_one, irq_pin_two}, 2'b11)
      rd(ADR_OUT_L, q); rd(ADR_OUT_H, q); count(c); `CHK(c, 13'd5)
      rd(ADR_OUT_H, q); count(c); `CHK({q, c}, {8'h00, 13'd5})
      wr(ADR_MODE, 8'h00); count(c); `CHK(c, 13'd0)
      wr(ADR_TH_LO, 8'h04); wr(ADR_PIN1, 8'h20); wr(ADR_MODE, 8'h06);
      fire_n(3); count(c); `CHK(c, 13'd4)
      rd(ADR_ST2, q); `CHK(q[6], 1'b1)
      `CHK(irq_pin_one, 1'b1)
      wr(ADR_MODE, 8'h00); wr(ADR_MODE, 8'h04);
      fire_n(2); count(c); `CHK(c, 13'd0)
      ev <= 8'h01; fire_n(3); count(c); `CHK(c, 13'd4)
      wr(ADR_MODE, 8'h00); wr(ADR_MODE, 8'h03);
      fire_n(3); rd(ADR_ST2, q); `CHK(q[6], 1'b0)
      ev <= 8'h00; fire_n(1); rd(ADR_ST2, q); `CHK(q[6], 1'b1)
      wr(ADR_MODE, 8'h00); wr(ADR_CC4, 8'h00); wr(ADR_DEC_A, 8'h02); wr(ADR_MODE, 8'h06);
      fire_n(4); count(c); `CHK(c, 13'd6)
      rd(ADR_OUT_L, q); `CHK(q, 8'h12)
      conclude();
   end
endmodule // test_inertial_sample_fifo
`default_nettype wire
